// ---- dimpi_pkg.sv ----
// constants for the digital i/o module process image block
package dimpi_pkg;
    // channel and connector counts
    localparam int IN_CHANNELS   = 16;
    localparam int IN_CONNECTORS = 8;
    localparam int OUT_CHANNELS  = 8;
    localparam int OUT_CONNECTORS = 4;
    // process image sizes in bytes
    localparam int IN_BYTES  = 2;
    localparam int OUT_BYTES = 1;
    // bit position of each pin within a connector pair
    localparam int PIN4_POS = 0;
    localparam int PIN2_POS = 1;
    // indicator encoding: one green and one red lamp per channel
    localparam logic [1:0] IND_DARK  = 2'h0;
    localparam logic [1:0] IND_GREEN = 2'h1;
    localparam logic [1:0] IND_RED   = 2'h2;
    // reset values
    localparam logic [15:0] IN_IMAGE_RST  = 16'h0000;
    localparam logic [7:0]  OUT_IMAGE_RST = 8'h00;
endpackage : dimpi_pkg

// ---- dimpi_top.sv ----
// process image and status indication for digital input and output modules
// timing seen at the ports, counted in rising edges of clk:
//   input pins change before edge 0
//   in_image shows the new pin state after edge 0
//   input lamps show the new state after edge 1
//   out_image sampled at the edge where out_image_valid is high (edge 0)
//   out_pin4 and out_pin2 change after edge 1
//   output lamps change after edge 2
//   a short shows red one edge after it is raised, whatever the channel does
//
// a short never forces an output off here; protection of the driver
// stage sits outside this block, the lamps only report the condition.
// odd bits of input_signal_pin_p4 carry nothing and are left unread.
`timescale 1ns/10ps
module dimpi_top
    import dimpi_pkg::*;
#(
    parameter int N_IN_CONN  = IN_CONNECTORS,
    parameter int N_OUT_CONN = OUT_CONNECTORS
)(
    input  wire logic                      clk,                 // 100 MHz clock
    input  wire logic                      rstn,                // async reset, active low
    input  wire logic [2*N_IN_CONN-1:0]    input_signal_pin_p4, // pin-4 input per connector
    input  wire logic [N_IN_CONN-1:0]      input_signal_pin_p2, // pin-2 input per connector
    input  wire logic [2*N_IN_CONN-1:0]    in_short,            // short detected per input channel
    output logic      [8*IN_BYTES-1:0]     in_image,            // input process image
    input  wire logic [8*OUT_BYTES-1:0]    out_image,           // output process image
    input  wire logic                      out_image_valid,     // out_image update strobe
    input  wire logic [2*N_OUT_CONN-1:0]   out_short,           // short detected per output channel
    output logic      [N_OUT_CONN-1:0]     out_pin4,            // pin-4 output per connector
    output logic      [N_OUT_CONN-1:0]     out_pin2,            // pin-2 output per connector
    output logic      [2*N_IN_CONN-1:0]    in_led_green,        // input indicator green lamps
    output logic      [2*N_IN_CONN-1:0]    in_led_red,          // input indicator red lamps
    output logic      [2*N_OUT_CONN-1:0]   out_led_green,       // output indicator green lamps
    output logic      [2*N_OUT_CONN-1:0]   out_led_red          // output indicator red lamps
);

    // widths derived once so every register and loop agrees
    localparam int IN_W  = 2*N_IN_CONN;    // input image bits
    localparam int OUT_W = 2*N_OUT_CONN;   // output image bits

    // refuse an empty input module, nothing would be mapped
    if (N_IN_CONN < 1)
    begin : g_bad_in_count
        $error("dimpi_top: at least one input connector is needed");
    end

    // refuse an empty output module
    if (N_OUT_CONN < 1)
    begin : g_bad_out_count
        $error("dimpi_top: at least one output connector is needed");
    end

    // input image must fill the input bytes exactly, no spare or missing bit
    if (IN_W != 8*IN_BYTES)
    begin : g_bad_in_size
        $error("dimpi_top: input connector count does not fill the input bytes");
    end

    // output image must match the output byte exactly
    if (OUT_W != 8*OUT_BYTES)
    begin : g_bad_out_size
        $error("dimpi_top: output connector count does not fill the output byte");
    end

    // indicator decode, fault takes precedence over active state
    function automatic logic [1:0] dimpi_ind(input logic active, input logic shorted);
        if (shorted)
            return IND_RED;
        else if (active)
            return IND_GREEN;
        else
            return IND_DARK;
    endfunction : dimpi_ind

    // green lamp lit for the active code only
    function automatic logic dimpi_green(input logic [1:0] code);
        return (code == IND_GREEN);
    endfunction : dimpi_green

    // red lamp lit for the fault code only, so both lamps never glow
    function automatic logic dimpi_red(input logic [1:0] code);
        return (code == IND_RED);
    endfunction : dimpi_red

    logic [IN_W-1:0]  in_image_next;            // assembled input image
    logic [OUT_W-1:0] out_image_reg;            // last loaded output byte
    logic [OUT_W-1:0] out_active;               // driven state per output channel
    logic [1:0]       in_ind_code  [IN_W];      // decoded input lamp state
    logic [1:0]       out_ind_code [OUT_W];     // decoded output lamp state

    // input image assembly: pin 4 even bit, pin 2 odd bit
    for (genvar k = 0; k < N_IN_CONN; k++)
    begin : g_in_map
        assign in_image_next[2*k+PIN4_POS] = input_signal_pin_p4[2*k];
        assign in_image_next[2*k+PIN2_POS] = input_signal_pin_p2[k];
    end

    // input image register, two bytes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            in_image <= IN_IMAGE_RST;
        else
            in_image <= in_image_next;
    end

    // output image capture, one byte
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            out_image_reg <= OUT_IMAGE_RST;
        else if (out_image_valid)
            out_image_reg <= out_image;
    end

    // output pin drive: even bit to pin 4, odd bit to pin 2
    for (genvar k = 0; k < N_OUT_CONN; k++)
    begin : g_out_map
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                out_pin4[k] <= 1'b0;
                out_pin2[k] <= 1'b0;
            end
            else
            begin
                out_pin4[k] <= out_image_reg[2*k+PIN4_POS];
                out_pin2[k] <= out_image_reg[2*k+PIN2_POS];
            end
        end
        assign out_active[2*k+PIN4_POS] = out_pin4[k];
        assign out_active[2*k+PIN2_POS] = out_pin2[k];
    end

    // input indicators follow the registered image, not the raw pins,
    // so a lamp never shows a state the interface unit has not seen
    for (genvar i = 0; i < IN_W; i++)
    begin : g_in_led
        assign in_ind_code[i] = dimpi_ind(in_image[i], in_short[i]);

        // lamp registers, one pair per input channel
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                in_led_green[i] <= 1'b0;
                in_led_red[i]   <= 1'b0;
            end
            else
            begin
                in_led_green[i] <= dimpi_green(in_ind_code[i]);
                in_led_red[i]   <= dimpi_red(in_ind_code[i]);
            end
        end
    end

    // output indicators follow the driven pins, so green means the
    // channel is really switched on, not merely requested
    for (genvar i = 0; i < OUT_W; i++)
    begin : g_out_led
        assign out_ind_code[i] = dimpi_ind(out_active[i], out_short[i]);

        // lamp registers, one pair per output channel
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                out_led_green[i] <= 1'b0;
                out_led_red[i]   <= 1'b0;
            end
            else
            begin
                out_led_green[i] <= dimpi_green(out_ind_code[i]);
                out_led_red[i]   <= dimpi_red(out_ind_code[i]);
            end
        end
    end

endmodule : dimpi_top

// ---- dimpi_asserts.sv ----
// port-level checks of the process image block
`timescale 1ns/10ps
module dimpi_asserts (
    input wire logic        clk, rstn, out_image_valid,
    input wire logic [15:0] input_signal_pin_p4, in_short, in_image, in_led_green, in_led_red,
    input wire logic [7:0]  input_signal_pin_p2, out_image, out_short, out_led_green, out_led_red,
    input wire logic [3:0]  out_pin4, out_pin2
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_in_lo; $past(rstn) |-> in_image[1:0] ==
        {$past(input_signal_pin_p2[0]), $past(input_signal_pin_p4[0])}; endproperty
    property p_in_hi; $past(rstn) |-> in_image[15:14] ==
        {$past(input_signal_pin_p2[7]), $past(input_signal_pin_p4[14])}; endproperty
    property p_out_lo; $past(out_image_valid, 2) |->
        {out_pin2[0], out_pin4[0]} == $past(out_image[1:0], 2); endproperty
    property p_out_hi; $past(out_image_valid, 2) |->
        {out_pin2[3], out_pin4[3]} == $past(out_image[7:6], 2); endproperty
    property p_out_hold; !$past(out_image_valid, 2) && $past(rstn, 2) |-> $stable(out_pin4);
    endproperty
    property p_in_red; in_short[0] |=> in_led_red[0] && !in_led_green[0]; endproperty
    property p_in_green; $past(input_signal_pin_p4[0], 2) && !$past(in_short[0])
        && $past(rstn, 2) |-> in_led_green[0] && !in_led_red[0]; endproperty
    property p_out_red; out_short[7] |=> out_led_red[7] && !out_led_green[7]; endproperty
    a_in_lo: assert property (p_in_lo) else $error("input image low pair wrong");
    a_in_hi: assert property (p_in_hi) else $error("input image high pair wrong");
    a_out_lo: assert property (p_out_lo) else $error("output pins low pair wrong");
    a_out_hi: assert property (p_out_hi) else $error("output pins high pair wrong");
    a_out_hold: assert property (p_out_hold) else $error("output pins moved unloaded");
    a_in_red: assert property (p_in_red) else $error("input lamp not red on short");
    a_in_green: assert property (p_in_green) else $error("input lamp not green");
    a_out_red: assert property (p_out_red) else $error("output lamp not red on short");
    c_in_fault: cover property (in_short[0] && input_signal_pin_p4[0]);
    c_back2back: cover property (out_image_valid [*2]);
    c_out_fault: cover property (out_short[7] && out_pin4[3]);
endmodule : dimpi_asserts
bind dimpi_top dimpi_asserts u_chk (.clk, .rstn, .out_image_valid, .input_signal_pin_p4,
    .in_short, .in_image, .in_led_green, .in_led_red, .input_signal_pin_p2, .out_image,
    .out_short, .out_led_green, .out_led_red, .out_pin4, .out_pin2);

// ---- dimpi_unit.sv ----
// interface unit model sending output bytes
`timescale 1ns/10ps
module dimpi_unit (
    input  wire logic clk,       // bench clock
    output logic [7:0] ob = 8'h00, // output byte
    output logic       vld = 1'b0  // load strobe
);
    // one whole byte per strobe, data inverted once released
    task send(input logic [7:0] b);
        @(posedge clk) {ob, vld} <= {b, 1'b1};
        @(posedge clk) {ob, vld} <= {~b, 1'b0};
    endtask : send
endmodule : dimpi_unit

// ---- test_digital_io_module_process_image.sv ----
// self-checking bench of the process image block
`timescale 1ns/10ps
module test_digital_io_module_process_image;
    logic clk = 0, rstn = 0, vld;
    logic [15:0] p4 = 0, ish = 0, img, ig, ir;
    logic [7:0] p2 = 0, osh = 0, ob, og, orr;
    logic [3:0] o4, o2;
    int fails = 0, total_checks = 0;
    always #5 clk = ~clk;
    dimpi_top i_dut (.clk, .rstn, .input_signal_pin_p4(p4), .input_signal_pin_p2(p2),
        .in_short(ish), .in_image(img), .out_image(ob), .out_image_valid(vld), .out_short(osh),
        .out_pin4(o4), .out_pin2(o2), .in_led_green(ig), .in_led_red(ir), .out_led_green(og),
        .out_led_red(orr));
    dimpi_unit i_unit (.clk, .ob, .vld);
    task chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin fails++; $display("mismatch %s exp %h got %h", n, e, s); end
    endtask : chk
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    // walking one over every input pin
    task t_in;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) {p4, p2} <= i[0] ? {16'h0, 8'h1 << i/2} : {16'h1 << i, 8'h0};
            repeat (3) @(posedge clk);
            #1 chk("in_image", img, 16'h1 << i);
            chk("in_green", ig, 16'h1 << i);
        end
        $display("t_in done");
    endtask : t_in
    // walking one over every output bit
    task t_out;
        for (int i = 0; i < 8; i++) begin
            i_unit.send(8'h1 << i);
            repeat (3) @(posedge clk);
            #1 chk("pin4", 16'(o4), i[0] ? 16'h0 : 16'h1 << i/2);
            chk("pin2", 16'(o2), i[0] ? 16'h1 << i/2 : 16'h0);
            chk("out_green", 16'(og), 16'h1 << i);
        end
        $display("t_out done");
    endtask : t_out
    // short on active channels, then cleared
    task t_short;
        @(posedge clk) {p4, p2, ish, osh} <= {16'h1, 8'h0, 16'h1, 8'h80};
        repeat (3) @(posedge clk);
        #1 chk("in_red", {ig, ir}, 32'h1);
        chk("out_red", {og, orr}, 16'h80);
        @(posedge clk) {ish, osh} <= 24'h0;
        repeat (3) @(posedge clk);
        #1 chk("in_clear", {ig, ir}, 32'h10000);
        chk("out_clear", {og, orr}, 16'h8000);
        $display("t_short done");
    endtask : t_short
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1;
        t_in();
        t_out();
        t_short();
        end_sim();
    end
    initial begin #100000; fails++; end_sim(); end
endmodule : test_digital_io_module_process_image
